// ---- inc/nvmv_pkg.sv ----
package nvmv_pkg;
	// image geometry: sixty-four 16-bit words, words 0x00 to 0x3F
	localparam int          NVMV_IMG_WORDS      = 64;
	localparam logic [5:0]  NVMV_IDX_CKVALID    = 6'h03;
	localparam logic [5:0]  NVMV_IDX_RSVD_ONES  = 6'h04;
	localparam logic [5:0]  NVMV_IDX_VERSION    = 6'h05;
	localparam logic [5:0]  NVMV_IDX_BOARD_LO   = 6'h08;
	localparam logic [5:0]  NVMV_IDX_BOARD_HI   = 6'h09;
	localparam logic [5:0]  NVMV_IDX_BOOTCAP    = 6'h33;
	localparam logic [5:0]  NVMV_IDX_CKSUM      = 6'h3F;
	// extra register indices, byte address is four times the index
	localparam logic [9:0]  NVMV_IDX_STATUS     = 10'h040;
	localparam logic [9:0]  NVMV_IDX_SUM        = 10'h041;
	localparam logic [9:0]  NVMV_IDX_CTRL       = 10'h042;
	// boot capability word fields
	localparam int          NVMV_SIG_HI         = 15;
	localparam int          NVMV_SIG_LO         = 14;
	localparam logic [1:0]  NVMV_SIG_VALID      = 2'h1;
	localparam int          NVMV_BIT_EXT_FW     = 3;
	localparam int          NVMV_BIT_UNDRV      = 1;
	localparam int          NVMV_BIT_BASE       = 0;
	// checksum_valid_flag_word fields
	localparam int          NVMV_BIT_LAN        = 11;
	localparam int          NVMV_BIT_CKVALID    = 1;
	// image version codes
	localparam logic [15:0] NVMV_VER_SWITCH     = 16'h0003;
	localparam logic [15:0] NVMV_VER_OTHER      = 16'h0004;
	// checksum target and start value
	localparam logic [15:0] NVMV_CKSUM_TARGET   = 16'hBABA;
	localparam logic [15:0] NVMV_SUM_INIT       = 16'h0000;
	// reset values of image words
	localparam logic [15:0] NVMV_RST_ONES       = 16'hFFFF;
	localparam logic [15:0] NVMV_RST_BOOTCAP    = 16'h4007;
	localparam logic [15:0] NVMV_RST_CKVALID    = 16'h0800;
	localparam logic [15:0] NVMV_RST_VERSION    = 16'h0004;
	localparam logic [15:0] NVMV_RST_OTHER      = 16'h0000;
	// status register bits
	localparam int          NVMV_ST_SIG         = 0;
	localparam int          NVMV_ST_MATCH       = 1;
	localparam int          NVMV_ST_CKFLAG      = 2;
	localparam int          NVMV_ST_BUSY        = 3;
	localparam int          NVMV_CTRL_START     = 0;
	// axi responses
	localparam logic [1:0]  NVMV_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  NVMV_RESP_DECERR    = 2'h3;

	typedef enum logic [1:0] {
		NVMV_IDLE  = 2'b00,
		NVMV_SCAN  = 2'b01,
		NVMV_LATCH = 2'b10
	} nvmv_scan_e;

	// power-up contents of one image word
	function automatic logic [15:0] nvmv_rst_word(input logic [5:0] idx);
		logic [15:0] v;
		v = NVMV_RST_OTHER;
		if (idx == NVMV_IDX_RSVD_ONES || idx == NVMV_IDX_BOARD_LO || idx == NVMV_IDX_BOARD_HI) begin
			v = NVMV_RST_ONES;
		end
		if (idx == NVMV_IDX_BOOTCAP) begin
			v = NVMV_RST_BOOTCAP;
		end
		if (idx == NVMV_IDX_CKVALID) begin
			v = NVMV_RST_CKVALID;
		end
		if (idx == NVMV_IDX_VERSION) begin
			v = NVMV_RST_VERSION;
		end
		return v;
	endfunction
endpackage

// ---- rtl/nvmv_sum_acc.sv ----
`timescale 1ns/100ps
// 16-bit additive accumulator, carry out dropped
module nvmv_sum_acc
	import nvmv_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	input  wire logic        clr,
	input  wire logic        add_en,
	input  wire logic [15:0] addend,
	output logic      [15:0] acc
);
	// plain 16-bit add wraps, so the carry is lost by width
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc <= NVMV_SUM_INIT;
		end else if (ce) begin
			if (clr) begin
				acc <= NVMV_SUM_INIT;
			end else if (add_en) begin
				acc <= acc + addend;
			end
		end
	end
endmodule

// ---- rtl/nvmv_validator.sv ----
`timescale 1ns/100ps
module nvmv_validator
	import nvmv_pkg::*;
#(
	parameter int AW = 12
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic          ce,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               image_config_valid,
	output logic               extended_firmware_code_present,
	output logic               universal_driver_present,
	output logic               base_code_present,
	output logic               board_mounted_lan_flag,
	output logic               switch_tuning,
	output logic [15:0]        image_version,
	output logic [31:0]        board_assembly_number,
	output logic               checksum_valid_flag
);
	logic [15:0] img_reg [NVMV_IMG_WORDS];
	logic        bvalid_reg;
	logic        rvalid_reg;
	logic [1:0]  bresp_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rdata_reg;
	nvmv_scan_e  scan_reg;
	logic [5:0]  scan_idx_reg;
	logic        rescan_reg;
	logic [15:0] sum_reg;
	logic        match_reg;
	logic [15:0] acc;

	// write channel decode; both address and data are taken in one edge
	wire         wr_take    = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
	wire  [9:0]  wr_idx     = s_axi_awaddr[AW-1:2];
	wire         wr_img     = wr_idx < 10'(NVMV_IMG_WORDS);
	wire         wr_ro      = (wr_idx == NVMV_IDX_STATUS) | (wr_idx == NVMV_IDX_SUM);
	wire         wr_ctrl    = wr_idx == NVMV_IDX_CTRL;
	wire         wr_ok      = wr_img | wr_ro | wr_ctrl;
	wire         img_we     = wr_take & wr_img;
	wire         start_req  = wr_take & wr_ctrl & s_axi_wstrb[0] & s_axi_wdata[NVMV_CTRL_START];
	assign s_axi_awready = ce & ~bvalid_reg & s_axi_wvalid;
	assign s_axi_wready  = ce & ~bvalid_reg & s_axi_awvalid;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	// the words that drive configuration
	wire  [15:0] cap_w      = img_reg[NVMV_IDX_BOOTCAP];
	wire  [15:0] ver_w      = img_reg[NVMV_IDX_VERSION];
	wire  [15:0] ck_w       = img_reg[NVMV_IDX_CKVALID];
	wire         sig_ok     = cap_w[NVMV_SIG_HI:NVMV_SIG_LO] == NVMV_SIG_VALID;

	// read channel decode; busy counts a pending rescan so a poll never sees a stale idle
	wire         rd_take    = ce & s_axi_arvalid & ~rvalid_reg;
	wire  [9:0]  rd_idx     = s_axi_araddr[AW-1:2];
	wire         rd_img     = rd_idx < 10'(NVMV_IMG_WORDS);
	wire  [15:0] rd_word    = img_reg[rd_idx[5:0]];
	wire  [31:0] status_w   = {28'h0000000, (scan_reg != NVMV_IDLE) | rescan_reg,
	                           ck_w[NVMV_BIT_CKVALID],
	                           match_reg, sig_ok};
	wire         rd_status  = rd_idx == NVMV_IDX_STATUS;
	wire         rd_sum     = rd_idx == NVMV_IDX_SUM;
	wire         rd_ctrl    = rd_idx == NVMV_IDX_CTRL;
	wire         rd_ok      = rd_img | rd_status | rd_sum | rd_ctrl;
	wire  [31:0] rd_mux     = rd_img ? {16'h0000, rd_word} :
	                          rd_status ? status_w :
	                          rd_sum ? {16'h0000, sum_reg} : 32'h00000000;
	assign s_axi_arready = ce & ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// image store: stored exactly as written, the block adds nothing of its own
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NVMV_IMG_WORDS; i++) begin
				img_reg[i] <= nvmv_rst_word(6'(i));
			end
		end else if (img_we) begin
			if (s_axi_wstrb[0]) begin
				img_reg[wr_idx[5:0]][7:0] <= s_axi_wdata[7:0];
			end
			if (s_axi_wstrb[1]) begin
				img_reg[wr_idx[5:0]][15:8] <= s_axi_wdata[15:8];
			end
		end
	end

	// write response; read-only registers ignore writes, unmapped gives decerr
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= NVMV_RESP_OKAY;
		end else if (ce) begin
			if (wr_take) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_ok ? NVMV_RESP_OKAY : NVMV_RESP_DECERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read data captured at the address edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= NVMV_RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end else if (ce) begin
			if (rd_take) begin
				rvalid_reg <= 1'b1;
				rresp_reg  <= rd_ok ? NVMV_RESP_OKAY : NVMV_RESP_DECERR;
				rdata_reg  <= rd_mux;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// software helper sum; it never feeds image validity, only the status and sum registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scan_reg     <= NVMV_IDLE;
			scan_idx_reg <= 6'h00;
			rescan_reg   <= 1'b1;
			sum_reg      <= NVMV_SUM_INIT;
			match_reg    <= 1'b0;
		end else if (ce) begin
			// a new write or start wins over the clear at scan launch
			if (img_we | start_req) begin
				rescan_reg <= 1'b1;
			end else if (scan_reg == NVMV_IDLE) begin
				rescan_reg <= 1'b0;
			end
			unique case (scan_reg)
				NVMV_IDLE: begin
					if (rescan_reg) begin
						scan_reg     <= NVMV_SCAN;
						scan_idx_reg <= 6'h00;
					end
				end
				NVMV_SCAN: begin
					scan_idx_reg <= scan_idx_reg + 6'h01;
					if (scan_idx_reg == NVMV_IDX_CKSUM) begin
						scan_reg <= NVMV_LATCH;
					end
				end
				NVMV_LATCH: begin
					sum_reg   <= acc;
					match_reg <= acc == NVMV_CKSUM_TARGET;
					scan_reg  <= NVMV_IDLE;
				end
				default: begin
					scan_reg <= NVMV_IDLE;
				end
			endcase
		end
	end

	// words written mid-scan make the result stale, hence the rescan flag
	nvmv_sum_acc u_acc (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.clr     (scan_reg == NVMV_IDLE),
		.add_en  (scan_reg == NVMV_SCAN),
		.addend  (img_reg[scan_idx_reg]),
		.acc     (acc)
	);

	// configuration follows the signature only; the sum plays no part
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			image_config_valid             <= 1'b0;
			extended_firmware_code_present <= NVMV_RST_BOOTCAP[NVMV_BIT_EXT_FW];
			universal_driver_present       <= NVMV_RST_BOOTCAP[NVMV_BIT_UNDRV];
			base_code_present              <= NVMV_RST_BOOTCAP[NVMV_BIT_BASE];
			board_mounted_lan_flag         <= NVMV_RST_CKVALID[NVMV_BIT_LAN];
			switch_tuning                  <= 1'b0;
			image_version                  <= NVMV_RST_VERSION;
			board_assembly_number          <= {NVMV_RST_ONES, NVMV_RST_ONES};
			checksum_valid_flag            <= 1'b0;
		end else if (ce) begin
			image_config_valid <= sig_ok;
			if (sig_ok) begin
				extended_firmware_code_present <= cap_w[NVMV_BIT_EXT_FW];
				universal_driver_present       <= cap_w[NVMV_BIT_UNDRV];
				base_code_present              <= cap_w[NVMV_BIT_BASE];
				board_mounted_lan_flag         <= ck_w[NVMV_BIT_LAN];
				switch_tuning                  <= ver_w == NVMV_VER_SWITCH;
				image_version                  <= ver_w;
				board_assembly_number          <= {img_reg[NVMV_IDX_BOARD_HI],
				                                   img_reg[NVMV_IDX_BOARD_LO]};
				checksum_valid_flag            <= ck_w[NVMV_BIT_CKVALID];
			end else begin
				extended_firmware_code_present <= NVMV_RST_BOOTCAP[NVMV_BIT_EXT_FW];
				universal_driver_present       <= NVMV_RST_BOOTCAP[NVMV_BIT_UNDRV];
				base_code_present              <= NVMV_RST_BOOTCAP[NVMV_BIT_BASE];
				board_mounted_lan_flag         <= NVMV_RST_CKVALID[NVMV_BIT_LAN];
				switch_tuning                  <= 1'b0;
				image_version                  <= NVMV_RST_VERSION;
				board_assembly_number          <= {NVMV_RST_ONES, NVMV_RST_ONES};
				checksum_valid_flag            <= 1'b0;
			end
		end
	end

	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_cfg_apply;
		ce && sig_ok |=> image_config_valid && universal_driver_present == $past(cap_w[1]);
	endproperty
	a_cfg_apply: assert property (p_cfg_apply) else $error("config not applied");

	property p_cfg_block;
		ce && !sig_ok |=> !image_config_valid && !extended_firmware_code_present;
	endproperty
	a_cfg_block: assert property (p_cfg_block) else $error("config applied bad sig");

	property p_no_sum_gate;
		ce && sig_ok && !match_reg |=> image_config_valid;
	endproperty
	a_no_sum_gate: assert property (p_no_sum_gate) else $error("sum gates validity");

	property p_ck_stored;
		img_we && wr_idx[5:0] == 6'h3F && s_axi_wstrb[1:0] == 2'h3
		|=> img_reg[63] == $past(s_axi_wdata[15:0]);
	endproperty
	a_ck_stored: assert property (p_ck_stored) else $error("checksum altered");

	property p_ck_read;
		rd_take && rd_idx == 10'h03F |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(img_reg[63]);
	endproperty
	a_ck_read: assert property (p_ck_read) else $error("checksum word read");

	property p_version;
		ce && sig_ok |=> switch_tuning == ($past(ver_w) == 16'h0003);
	endproperty
	a_version: assert property (p_version) else $error("version decode");

	property p_scan_end;
		ce && scan_reg == NVMV_LATCH |=> scan_reg == NVMV_IDLE && match_reg == (sum_reg == 16'hBABA);
	endproperty
	a_scan_end: assert property (p_scan_end) else $error("scan result");

	property p_acc_add;
		ce && scan_reg == NVMV_SCAN |=> acc == 16'($past(acc) + $past(img_reg[scan_idx_reg]));
	endproperty
	a_acc_add: assert property (p_acc_add) else $error("sum wrap");

	property p_ckflag;
		rd_take && rd_status |=> s_axi_rdata[2] == $past(ck_w[1]) && s_axi_rdata[0] == $past(sig_ok);
	endproperty
	a_ckflag: assert property (p_ckflag) else $error("status bits");

	property p_bhold;
		s_axi_bvalid && !(ce && s_axi_bready) |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");

	c_match: cover property (scan_reg == NVMV_LATCH ##1 match_reg);
	c_write: cover property (wr_take && wr_img);
	c_decerr: cover property (rd_take && !rd_ok);
	c_sig: cover property (!sig_ok ##1 sig_ok);
endmodule

// ---- bench/nvmv_sw_model.sv ----
`timescale 1ns/100ps
// software side of the register bus, keeps a shadow of the image it writes
module nvmv_sw_model
	import nvmv_pkg::*;
(
	input  wire logic        clk,
	output logic [11:0]      awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	output logic [11:0]      araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	logic [15:0] img [64];

	// idle bus and power-up image contents
	initial begin
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		foreach (img[i])
			img[i] = NVMV_RST_OTHER;
		img[3] = NVMV_RST_CKVALID;
		img[4] = NVMV_RST_ONES;
		img[5] = NVMV_RST_VERSION;
		img[8] = NVMV_RST_ONES;
		img[9] = NVMV_RST_ONES;
		img[51] = NVMV_RST_BOOTCAP;
	end

	// last word chosen so the wrapped sum hits the target
	function automatic logic [15:0] cks();
		logic [15:0] s;
		s = NVMV_SUM_INIT;
		for (int i = 0; i < 63; i++)
			s = s + img[i];
		return NVMV_CKSUM_TARGET - s;
	endfunction

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r, output bit to);
		int n;
		n = 0;
		to = 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 200) begin
			@(posedge clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				to = 1'b0;
				n = 200;
			end
		end
		if (!to && r === NVMV_RESP_OKAY && a[11:8] == 4'h0) begin
			if (s[0])
				img[a[7:2]][7:0] = d[7:0];
			if (s[1])
				img[a[7:2]][15:8] = d[15:8];
		end
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic [1:0] r,
		output bit to);
		int n;
		n = 0;
		to = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 200) begin
			@(posedge clk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				q = rdata;
				r = rresp;
				rready <= 1'b0;
				to = 1'b0;
				n = 200;
			end
		end
	endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench import nvmv_pkg::*;;
	localparam logic [11:0] A_ST  = {NVMV_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_SUM = {NVMV_IDX_SUM, 2'b00};
	localparam logic [11:0] A_CTL = {NVMV_IDX_CTRL, 2'b00};
	logic        clk;
	logic        sys_rst;
	logic        ce;
	logic [11:0] awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [11:0] araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	wire  [6:0]  flags;
	logic [15:0] ver;
	logic [31:0] bnum;
	int          err_total;
	int          n_tests;
	logic [1:0]  r;
	logic [31:0] q;
	logic [15:0] c;
	logic [15:0] bad_sum;

	always #5 clk = ~clk;

	nvmv_validator nvmv_validator_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.image_config_valid(flags[6]), .extended_firmware_code_present(flags[5]),
		.universal_driver_present(flags[4]), .base_code_present(flags[3]),
		.board_mounted_lan_flag(flags[2]), .switch_tuning(flags[1]), .image_version(ver),
		.board_assembly_number(bnum), .checksum_valid_flag(flags[0]));

	nvmv_sw_model nvmv_sw_model_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask

	// a wait that ran out ends the run at once
	task automatic hang(input bit to);
		if (to) begin
			$display("Error bus answer expected 1 seen 0");
			err_total++;
			finish_test();
		end
	endtask

	function automatic logic [11:0] iw(input logic [5:0] i);
		return {4'h0, i, 2'b00};
	endfunction

	// the step after the response edge lets the outputs settle
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		bit to;
		nvmv_sw_model_i.wr(a, d, s, r, to);
		hang(to);
		#1;
	endtask

	task automatic rd(input logic [11:0] a);
		bit to;
		nvmv_sw_model_i.rd(a, q, r, to);
		hang(to);
		#1;
	endtask

	task automatic wait_scan();
		int n;
		n = 0;
		q = 32'h00000008;
		while (q[NVMV_ST_BUSY] && n < 100) begin
			rd(A_ST);
			n++;
		end
		hang(q[NVMV_ST_BUSY]);
	endtask

	task automatic t_reset();
		logic [5:0] ix [6];
		ix = '{6'h03, 6'h04, 6'h05, 6'h08, 6'h09, 6'h33};
		foreach (ix[i]) begin
			rd(iw(ix[i]));
			chk("reset word", q, {16'h0000, nvmv_sw_model_i.img[ix[i]]});
		end
		chk("reset flags", 32'(flags), 32'(7'b1011100));
		chk("reset version", 32'(ver), 32'(NVMV_VER_OTHER));
		chk("reset board number", bnum, 32'hFFFFFFFF);
		$display("done reset");
	endtask

	// full image: capabilities, switch tuning, board number, sealed checksum
	task automatic t_image();
		wr(iw(NVMV_IDX_BOOTCAP), 32'h0000400D, 4'h3);
		wr(iw(NVMV_IDX_VERSION), 32'(NVMV_VER_SWITCH), 4'h3);
		wr(iw(NVMV_IDX_BOARD_LO), 32'h00001234, 4'h3);
		wr(iw(NVMV_IDX_BOARD_HI), 32'h00005603, 4'h3);
		chk("board number", bnum, 32'h56031234);
		// product kind is judged from the version word, never from the board number
		chk("version", 32'(ver), 32'(NVMV_VER_SWITCH));
		wr(iw(NVMV_IDX_CKVALID), 32'h00000802, 4'h3);
		c = nvmv_sw_model_i.cks();
		wr(iw(NVMV_IDX_CKSUM), {16'h0000, c}, 4'h3);
		wr(A_CTL, 32'h00000001, 4'h1);
		wait_scan();
		chk("status", q, 32'h00000007);
		rd(A_SUM);
		chk("sum", q, 32'(NVMV_CKSUM_TARGET));
		rd(iw(NVMV_IDX_CKSUM));
		chk("checksum stored", q, {16'h0000, c});
		chk("image flags", 32'(flags), 32'(7'b1101111));
		$display("done image");
	endtask

	// low byte only: bit 0 of the checksum flipped, high byte garbage ignored
	task automatic t_badsum();
		wr(iw(NVMV_IDX_CKSUM), {16'hFFFF, ~c[15:8], c[7:0] ^ 8'h01}, 4'h1);
		rd(iw(NVMV_IDX_CKSUM));
		chk("strobed word", q, {16'h0000, c ^ 16'h0001});
		bad_sum = NVMV_CKSUM_TARGET - c + (c ^ 16'h0001);
		wait_scan();
		chk("bad status", q, 32'h00000005);
		rd(A_SUM);
		chk("bad sum", q, 32'(bad_sum));
		chk("bad flags", 32'(flags), 32'(7'b1101111));
		$display("done bad checksum");
	endtask

	task automatic t_map();
		rd(12'h10C);
		chk("unmapped read resp", 32'(r), 32'(NVMV_RESP_DECERR));
		chk("unmapped read data", q, 32'h00000000);
		wr(12'h10C, 32'h0000FFFF, 4'hF);
		chk("unmapped write resp", 32'(r), 32'(NVMV_RESP_DECERR));
		wr(A_SUM, 32'h00001234, 4'h3);
		chk("sum write resp", 32'(r), 32'(NVMV_RESP_OKAY));
		rd(A_SUM);
		chk("sum unchanged", q, 32'(bad_sum));
		$display("done map");
	endtask

	// frozen clock enable: readies drop and a running scan stops where it is
	task automatic t_ce();
		wr(A_CTL, 32'h00000001, 4'h1);
		@(posedge clk);
		ce <= 1'b0;
		repeat (100) @(posedge clk);
		chk("frozen arready", 32'(arready), 32'h0);
		chk("frozen flags", 32'(flags), 32'(7'b1101111));
		ce <= 1'b1;
		rd(A_ST);
		chk("frozen busy", 32'(q[NVMV_ST_BUSY]), 32'h1);
		wait_scan();
		chk("resumed status", q, 32'h00000005);
		$display("done clock enable");
	endtask

	// every invalid signature code drops the configuration to defaults
	task automatic t_sig();
		logic [1:0] code [3];
		code = '{2'h0, 2'h2, 2'h3};
		foreach (code[i]) begin
			wr(iw(NVMV_IDX_BOOTCAP), {16'h0000, code[i], 14'h000D}, 4'h3);
			chk("invalid flags", 32'(flags), 32'(7'b0011100));
			rd(A_ST);
			chk("invalid status bit", 32'(q[NVMV_ST_SIG]), 32'h0);
		end
		wr(iw(NVMV_IDX_BOOTCAP), 32'h0000400D, 4'h3);
		chk("valid again flags", 32'(flags), 32'(7'b1101111));
		$display("done signature");
	endtask

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		ce = 1'b1;
		err_total = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_image();
		t_badsum();
		t_map();
		t_ce();
		t_sig();
		finish_test();
	end
endmodule
